/* hw/rss_pkg.sv */
// Constants for the radio setup and status register group
package rss_pkg;

	// Register offsets on the serial register port
	localparam logic [4:0] REG_CONFIG = 5'h00;
	localparam logic [4:0] REG_PIPE_ENABLES = 5'h02;
	localparam logic [4:0] REG_ADDRESS_WIDTH = 5'h03;
	localparam logic [4:0] REG_RETRY_SETUP = 5'h04;
	localparam logic [4:0] REG_CHANNEL_SELECT = 5'h05;
	localparam logic [4:0] REG_RADIO_SETUP = 5'h06;
	localparam logic [4:0] REG_EVENT_STATUS = 5'h07;

	// Command byte layout: three-bit opcode above a five-bit register offset
	localparam int CMD_OP_MSB = 7;
	localparam int CMD_OP_LSB = 5;
	localparam logic [2:0] CMD_OP_READ = 3'h0;
	localparam logic [2:0] CMD_OP_WRITE = 3'h1;

	// Reset values
	localparam logic [6:0] CONFIG_RESET = 7'h08;
	localparam logic [5:0] PIPE_ENABLES_RESET = 6'h03;
	localparam logic [1:0] ADDRESS_WIDTH_RESET = 2'h3;
	localparam logic [3:0] RETRY_DELAY_RESET = 4'h0;
	localparam logic [3:0] RETRY_COUNT_RESET = 4'h3;
	localparam logic [6:0] CHANNEL_RESET = 7'h02;
	localparam logic [4:0] RADIO_SETUP_RESET = 5'h0F;
	localparam logic [2:0] PIPE_EMPTY_CODE = 3'h7;

	// Field positions
	localparam int CFG_MASK_RX_BIT = 6;
	localparam int CFG_MASK_TX_BIT = 5;
	localparam int CFG_MASK_RT_BIT = 4;
	localparam int RETRY_DELAY_LSB = 4;
	localparam int RETRY_COUNT_LSB = 0;
	localparam int RADIO_PLL_FORCE_BIT = 4;
	localparam int RADIO_RATE_BIT = 3;
	localparam int RADIO_POWER_LSB = 1;
	localparam int RADIO_GAIN_BIT = 0;
	localparam int STAT_RX_READY_BIT = 6;
	localparam int STAT_DATA_SENT_BIT = 5;
	localparam int STAT_RETRY_LIMIT_BIT = 4;
	localparam int STAT_PIPE_LSB = 1;
	localparam int STAT_TX_FULL_BIT = 0;

	// Address width codes
	localparam logic [1:0] AW_ILLEGAL = 2'h0;
	localparam int AW_MAX_BYTES = 5;

	// Retransmit delay timing
	localparam int CLK_FREQ_HZ = 40000000;
	localparam int RETRY_UNIT_US = 250;
	localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_US * (CLK_FREQ_HZ / 1000000);

endpackage : rss_pkg

/* hw/rss_retry_timer.sv */
// Retransmit delay and attempt counter
`timescale 1ns/1ps

module rss_retry_timer #(
	parameter int UNIT_CYCLES = rss_pkg::RETRY_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] delay_code,
	input wire logic [3:0] count_limit,
	input wire logic tx_begin,
	input wire logic tx_no_ack,
	input wire logic blocked,
	output logic retransmit_go,
	output logic limit_hit,
	output logic [3:0] attempts
);

	localparam int UW = $clog2(UNIT_CYCLES + 1);

	typedef enum logic [0:0] {RSS_RT_IDLE, RSS_RT_WAIT} rss_rt_state_t;

	rss_rt_state_t state_q, state_d;
	logic [UW-1:0] unit_cnt_q, unit_cnt_d;
	logic [3:0] units_q, units_d;
	logic [3:0] attempts_q, attempts_d;
	logic go_q, go_d;
	logic hit_q, hit_d;

	// Refuse a unit length below one clock cycle
	if (UNIT_CYCLES < 1) begin : g_bad_unit
		$error("rss_retry_timer: UNIT_CYCLES must be at least 1");
	end

	// Delay is (code + 1) units of 250 us from end of one send to the next
	always_comb begin
		state_d = state_q;
		unit_cnt_d = unit_cnt_q;
		units_d = units_q;
		attempts_d = attempts_q;
		go_d = 1'b0;
		hit_d = 1'b0;
		if (tx_begin) begin
			attempts_d = 4'h0;
		end
		unique case (state_q)
			RSS_RT_IDLE: begin
				// A set limit flag blocks any further attempt until cleared
				if (tx_no_ack && !blocked) begin
					if (attempts_q >= count_limit) begin
						hit_d = 1'b1;
					end else begin
						state_d = RSS_RT_WAIT;
						unit_cnt_d = '0;
						units_d = 4'h0;
					end
				end
			end
			RSS_RT_WAIT: begin
				if (unit_cnt_q == UW'(UNIT_CYCLES - 1)) begin
					unit_cnt_d = '0;
					if (units_q == delay_code) begin
						state_d = RSS_RT_IDLE;
						go_d = 1'b1;
						attempts_d = attempts_q + 4'h1;
					end else begin
						units_d = units_q + 4'h1;
					end
				end else begin
					unit_cnt_d = unit_cnt_q + UW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= RSS_RT_IDLE;
			unit_cnt_q <= '0;
			units_q <= 4'h0;
			attempts_q <= 4'h0;
			go_q <= 1'b0;
			hit_q <= 1'b0;
		end else begin
			state_q <= state_d;
			unit_cnt_q <= unit_cnt_d;
			units_q <= units_d;
			attempts_q <= attempts_d;
			go_q <= go_d;
			hit_q <= hit_d;
		end
	end

	assign retransmit_go = go_q;
	assign limit_hit = hit_q;
	assign attempts = attempts_q;

endmodule : rss_retry_timer

/* hw/rss_regs.sv */
// Radio setup and status registers behind the serial register port
`timescale 1ns/1ps

// Operation
// - Two-bit address width code, 00 illegal, reset 11
// - Short widths use low address bytes only
// - Retry wait is 250 us times code+1
// - Retry count field limits retransmissions, reset 0011
// - Seven-bit channel field, reset 2, bit7 zero
// - Output power code applied while transmitting, reset 11
// - Status shifts out during each command byte
// - Receive ready flag sets, cleared writing one
// - Data sent flag, after acknowledge if enabled
// - Retry limit flag blocks traffic until cleared
// - Pipe field reports head pipe, 111 empty
// - Bit zero shows transmit queue full
// - Active-low interrupt while unmasked flag set
// - Mask bit one keeps flag off interrupt
module rss_regs #(
	parameter int RETRY_UNIT_CYCLES = rss_pkg::RETRY_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_sck,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic rx_payload_stored,
	input wire logic [2:0] rx_head_pipe,
	input wire logic tx_queue_full,
	input wire logic tx_packet_sent,
	input wire logic ack_received,
	input wire logic auto_acknowledge,
	input wire logic tx_active,
	input wire logic tx_begin,
	input wire logic tx_no_ack,
	input wire logic [39:0] stored_address,
	output logic irq_n,
	output logic [5:0] pipe_receive_enable,
	output logic [2:0] address_bytes,
	output logic [39:0] address_used,
	output logic [6:0] channel_number,
	output logic air_rate_select,
	output logic [1:0] output_power_code,
	output logic power_amp_enable,
	output logic pll_lock_force,
	output logic receiver_gain_setup,
	output logic retransmit_go,
	output logic comm_blocked
);

	// Bytes selected by a width code; the illegal code is never stored
	function automatic logic [2:0] aw_bytes(input logic [1:0] code);
		aw_bytes = 3'(code) + 3'h2;
	endfunction : aw_bytes

	// Port pin synchronisers; only stage two and the edge copy are read
	logic sck_s1_q, sck_s2_q, sck_s3_q;
	logic csn_n_s1_q, csn_n_s2_q, csn_n_s3_q;
	logic mosi_s1_q, mosi_s2_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			csn_n_s1_q <= 1'b1;
			csn_n_s2_q <= 1'b1;
			csn_n_s3_q <= 1'b1;
			mosi_s1_q <= 1'b0;
			mosi_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= spi_sck;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			csn_n_s1_q <= spi_csn_n;
			csn_n_s2_q <= csn_n_s1_q;
			csn_n_s3_q <= csn_n_s2_q;
			mosi_s1_q <= spi_mosi;
			mosi_s2_q <= mosi_s1_q;
		end
	end

	logic sck_rise, sck_fall, csn_fall;
	assign sck_rise = sck_s2_q & ~sck_s3_q;
	assign sck_fall = ~sck_s2_q & sck_s3_q;
	assign csn_fall = ~csn_n_s2_q & csn_n_s3_q;

	// Register state
	logic [6:0] config_q, config_d;
	logic [5:0] pipe_en_q, pipe_en_d;
	logic [1:0] aw_code_q, aw_code_d;
	logic [3:0] delay_code_q, delay_code_d;
	logic [3:0] count_limit_q, count_limit_d;
	logic [6:0] channel_q, channel_d;
	logic [4:0] radio_q, radio_d;
	logic rx_ready_q, rx_ready_d;
	logic data_sent_q, data_sent_d;
	logic retry_limit_q, retry_limit_d;
	logic [2:0] pipe_no_q, pipe_no_d;
	logic tx_full_q, tx_full_d;
	logic irq_n_q, irq_n_d;
	logic [2:0] bytes_q, bytes_d;
	logic [39:0] addr_used_q, addr_used_d;
	logic pa_en_q, pa_en_d;

	// Serial engine state
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic first_byte_q, first_byte_d;
	logic [7:0] cmd_q, cmd_d;
	logic [7:0] rx_shift_q, rx_shift_d;
	logic [7:0] tx_shift_q, tx_shift_d;
	logic oe_q, oe_d;

	logic [7:0] status_byte;
	logic [7:0] rd_data;
	logic [7:0] wr_data;
	logic wr_en;
	logic limit_hit;
	logic rt_go;

	// Live status image, reserved bit 7 reads zero
	assign status_byte = {1'b0, rx_ready_q, data_sent_q, retry_limit_q, pipe_no_q, tx_full_q};

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		rd_data = 8'h00;
		unique case (cmd_q[4:0])
			rss_pkg::REG_CONFIG: rd_data = {1'b0, config_q};
			rss_pkg::REG_PIPE_ENABLES: rd_data = {2'h0, pipe_en_q};
			rss_pkg::REG_ADDRESS_WIDTH: rd_data = {6'h00, aw_code_q};
			rss_pkg::REG_RETRY_SETUP: rd_data = {delay_code_q, count_limit_q};
			rss_pkg::REG_CHANNEL_SELECT: rd_data = {1'b0, channel_q};
			rss_pkg::REG_RADIO_SETUP: rd_data = {3'h0, radio_q};
			rss_pkg::REG_EVENT_STATUS: rd_data = status_byte;
			default: rd_data = 8'h00;
		endcase
	end

	// Byte framing: sample on rising clock, shift out on falling clock
	always_comb begin
		bit_cnt_d = bit_cnt_q;
		first_byte_d = first_byte_q;
		cmd_d = cmd_q;
		rx_shift_d = rx_shift_q;
		tx_shift_d = tx_shift_q;
		oe_d = ~csn_n_s2_q;
		wr_en = 1'b0;
		wr_data = {rx_shift_q[6:0], mosi_s2_q};
		if (csn_n_s2_q) begin
			bit_cnt_d = 3'h0;
			first_byte_d = 1'b1;
		end else if (csn_fall) begin
			// Status goes out first while the command comes in
			tx_shift_d = status_byte;
			bit_cnt_d = 3'h0;
			first_byte_d = 1'b1;
		end else begin
			if (sck_rise) begin
				rx_shift_d = wr_data;
				bit_cnt_d = bit_cnt_q + 3'h1;
				if (bit_cnt_q == 3'h7) begin
					if (first_byte_q) begin
						cmd_d = wr_data;
						first_byte_d = 1'b0;
					end else if (cmd_q[rss_pkg::CMD_OP_MSB:rss_pkg::CMD_OP_LSB]
							== rss_pkg::CMD_OP_WRITE) begin
						wr_en = 1'b1;
					end
				end
			end
			if (sck_fall) begin
				if (bit_cnt_q == 3'h0) begin
					// Byte boundary: data bytes carry the read value or zero
					if (cmd_q[rss_pkg::CMD_OP_MSB:rss_pkg::CMD_OP_LSB]
							== rss_pkg::CMD_OP_READ) begin
						tx_shift_d = rd_data;
					end else begin
						tx_shift_d = 8'h00;
					end
				end else begin
					tx_shift_d = {tx_shift_q[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt_q <= 3'h0;
			first_byte_q <= 1'b1;
			cmd_q <= 8'h00;
			rx_shift_q <= 8'h00;
			tx_shift_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			first_byte_q <= first_byte_d;
			cmd_q <= cmd_d;
			rx_shift_q <= rx_shift_d;
			tx_shift_q <= tx_shift_d;
			oe_q <= oe_d;
		end
	end

	// Register updates, event flags and derived outputs
	always_comb begin
		config_d = config_q;
		pipe_en_d = pipe_en_q;
		aw_code_d = aw_code_q;
		delay_code_d = delay_code_q;
		count_limit_d = count_limit_q;
		channel_d = channel_q;
		radio_d = radio_q;
		rx_ready_d = rx_ready_q;
		data_sent_d = data_sent_q;
		retry_limit_d = retry_limit_q;
		if (wr_en) begin
			unique case (cmd_q[4:0])
				rss_pkg::REG_CONFIG: config_d = wr_data[6:0];
				rss_pkg::REG_PIPE_ENABLES: pipe_en_d = wr_data[5:0];
				rss_pkg::REG_ADDRESS_WIDTH: begin
					// The illegal code is refused and the old width kept
					if (wr_data[1:0] != rss_pkg::AW_ILLEGAL) begin
						aw_code_d = wr_data[1:0];
					end
				end
				rss_pkg::REG_RETRY_SETUP: begin
					delay_code_d = wr_data[rss_pkg::RETRY_DELAY_LSB +: 4];
					count_limit_d = wr_data[rss_pkg::RETRY_COUNT_LSB +: 4];
				end
				rss_pkg::REG_CHANNEL_SELECT: channel_d = wr_data[6:0];
				rss_pkg::REG_RADIO_SETUP: radio_d = wr_data[4:0];
				rss_pkg::REG_EVENT_STATUS: begin
					// Ones clear, zeros leave a flag alone
					rx_ready_d = rx_ready_q & ~wr_data[rss_pkg::STAT_RX_READY_BIT];
					data_sent_d = data_sent_q & ~wr_data[rss_pkg::STAT_DATA_SENT_BIT];
					retry_limit_d = retry_limit_q & ~wr_data[rss_pkg::STAT_RETRY_LIMIT_BIT];
				end
				default: ;
			endcase
		end
		// Set wins over a clear landing in the same cycle
		rx_ready_d = rx_ready_d | rx_payload_stored;
		data_sent_d = data_sent_d | (auto_acknowledge ? ack_received : tx_packet_sent);
		retry_limit_d = retry_limit_d | limit_hit;
		pipe_no_d = rx_head_pipe;
		tx_full_d = tx_queue_full;
		irq_n_d = ~((rx_ready_d & ~config_d[rss_pkg::CFG_MASK_RX_BIT])
			| (data_sent_d & ~config_d[rss_pkg::CFG_MASK_TX_BIT])
			| (retry_limit_d & ~config_d[rss_pkg::CFG_MASK_RT_BIT]));
		bytes_d = aw_bytes(aw_code_d);
		// Upper address bytes beyond the selected width are dropped
		for (int i = 0; i < rss_pkg::AW_MAX_BYTES; i++) begin
			addr_used_d[8*i +: 8] = (i < int'(bytes_d)) ? stored_address[8*i +: 8] : 8'h00;
		end
		pa_en_d = tx_active;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			config_q <= rss_pkg::CONFIG_RESET;
			pipe_en_q <= rss_pkg::PIPE_ENABLES_RESET;
			aw_code_q <= rss_pkg::ADDRESS_WIDTH_RESET;
			delay_code_q <= rss_pkg::RETRY_DELAY_RESET;
			count_limit_q <= rss_pkg::RETRY_COUNT_RESET;
			channel_q <= rss_pkg::CHANNEL_RESET;
			radio_q <= rss_pkg::RADIO_SETUP_RESET;
			rx_ready_q <= 1'b0;
			data_sent_q <= 1'b0;
			retry_limit_q <= 1'b0;
			pipe_no_q <= rss_pkg::PIPE_EMPTY_CODE;
			tx_full_q <= 1'b0;
			irq_n_q <= 1'b1;
			bytes_q <= 3'h5;
			addr_used_q <= 40'h00_0000_0000;
			pa_en_q <= 1'b0;
		end else begin
			config_q <= config_d;
			pipe_en_q <= pipe_en_d;
			aw_code_q <= aw_code_d;
			delay_code_q <= delay_code_d;
			count_limit_q <= count_limit_d;
			channel_q <= channel_d;
			radio_q <= radio_d;
			rx_ready_q <= rx_ready_d;
			data_sent_q <= data_sent_d;
			retry_limit_q <= retry_limit_d;
			pipe_no_q <= pipe_no_d;
			tx_full_q <= tx_full_d;
			irq_n_q <= irq_n_d;
			bytes_q <= bytes_d;
			addr_used_q <= addr_used_d;
			pa_en_q <= pa_en_d;
		end
	end

	// Retransmit pacing, stalled while the limit flag stands
	rss_retry_timer #(
		.UNIT_CYCLES(RETRY_UNIT_CYCLES)
	) u_retry (
		.clk(clk),
		.sys_rst(sys_rst),
		.delay_code(delay_code_q),
		.count_limit(count_limit_q),
		.tx_begin(tx_begin),
		.tx_no_ack(tx_no_ack),
		.blocked(retry_limit_q),
		.retransmit_go(rt_go),
		.limit_hit(limit_hit),
		.attempts()
	);

	// Outputs straight from flip-flops
	assign spi_miso = tx_shift_q[7];
	assign spi_miso_oe = oe_q;
	assign irq_n = irq_n_q;
	assign pipe_receive_enable = pipe_en_q;
	assign address_bytes = bytes_q;
	assign address_used = addr_used_q;
	assign channel_number = channel_q;
	assign air_rate_select = radio_q[rss_pkg::RADIO_RATE_BIT];
	assign output_power_code = radio_q[rss_pkg::RADIO_POWER_LSB +: 2];
	assign power_amp_enable = pa_en_q;
	assign pll_lock_force = radio_q[rss_pkg::RADIO_PLL_FORCE_BIT];
	assign receiver_gain_setup = radio_q[rss_pkg::RADIO_GAIN_BIT];
	assign retransmit_go = rt_go;
	assign comm_blocked = retry_limit_q;

endmodule : rss_regs

/* testbench/rss_regs_monitor.sv */
// Port checker for the radio setup and status registers
`timescale 1ns/1ps

module rss_regs_monitor #(
	parameter int RETRY_UNIT_CYCLES = rss_pkg::RETRY_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_csn_n,
	input wire logic spi_miso_oe,
	input wire logic tx_active,
	input wire logic power_amp_enable,
	input wire logic tx_no_ack,
	input wire logic [39:0] stored_address,
	input wire logic [2:0] address_bytes,
	input wire logic [39:0] address_used,
	input wire logic retransmit_go,
	input wire logic comm_blocked,
	input wire logic irq_n
);
	logic [31:0] gap_q;
	logic [31:0] gap_d;

	// Cycles since the last missed acknowledge; wide enough for the longest real delay
	always_comb begin
		gap_d = gap_q;
		if (tx_no_ack)
			gap_d = 32'h0000_0000;
		else if (gap_q != 32'hFFFF_FFFF)
			gap_d = gap_q + 32'h0000_0001;
	end

	// Register for the gap counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			gap_q <= 32'hFFFF_FFFF;
		else
			gap_q <= gap_d;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Loose window on the delay; the bench checks the code 1 figure to within a few cycles
	AST_AMP_FOLLOWS: assert property ($rose(tx_active) |=> power_amp_enable)
		else $error("amplifier missed transmit");
	AST_WIDTH_LEGAL: assert property (address_bytes inside {3'h3, 3'h4, 3'h5})
		else $error("illegal address width");
	AST_SHORT_ADDR: assert property (address_bytes == 3'h3 ##1 address_bytes == 3'h3 |->
		address_used == {16'h0000, $past(stored_address[23:0])})
		else $error("short address not masked");
	AST_LIMIT_CAUSE: assert property ($rose(comm_blocked) |->
		$past(tx_no_ack) || $past(tx_no_ack, 2) || $past(tx_no_ack, 3))
		else $error("block without missed ack");
	AST_BLOCK_QUIET: assert property (comm_blocked |-> !retransmit_go)
		else $error("resend while blocked");
	AST_GO_PULSE: assert property (retransmit_go |=> !retransmit_go)
		else $error("resend longer than a cycle");
	AST_GO_DELAY: assert property (retransmit_go |-> gap_q >= 32'(RETRY_UNIT_CYCLES)
		&& gap_q <= 32'(16 * RETRY_UNIT_CYCLES))
		else $error("resend delay out of range");
	AST_OE_ON: assert property (!spi_csn_n [*6] |-> spi_miso_oe)
		else $error("status not driven in frame");
	AST_OE_OFF: assert property (spi_csn_n [*6] |-> !spi_miso_oe)
		else $error("miso driven outside frame");

	COV_GO: cover property (retransmit_go);
	COV_BLOCK: cover property ($rose(comm_blocked));
	COV_IRQ: cover property ($fell(irq_n));
endmodule : rss_regs_monitor

bind rss_regs rss_regs_monitor #(.RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)) u_mon (
	.clk(clk), .sys_rst(sys_rst), .spi_csn_n(spi_csn_n), .spi_miso_oe(spi_miso_oe),
	.tx_active(tx_active), .power_amp_enable(power_amp_enable), .tx_no_ack(tx_no_ack),
	.stored_address(stored_address), .address_bytes(address_bytes),
	.address_used(address_used), .retransmit_go(retransmit_go),
	.comm_blocked(comm_blocked), .irq_n(irq_n)
);

/* testbench/rss_host_model.sv */
// Serial host model driving the register port in mode 0
`timescale 1ns/1ps

module rss_host_model (
	input wire logic clk,
	output logic sck,
	output logic csn_n,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sck = 1'h0;
		csn_n = 1'h1;
		mosi = 1'h0;
	end

	// Half a bit is four clk cycles; miso is taken as sck rises
	task automatic shift(input logic [7:0] o, output logic [7:0] i);
		for (int b = 7; b >= 0; b--) begin
			mosi <= o[b];
			repeat (4) @(posedge clk);
			sck <= 1'h1;
			i[b] = miso;
			repeat (4) @(posedge clk);
			sck <= 1'h0;
		end
	endtask : shift

	// Sck idles low between frames; mosi shows the inverse of its last bit
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
		output logic [7:0] st, output logic [7:0] rd);
		csn_n <= 1'h0;
		repeat (8) @(posedge clk);
		shift(cmd, st);
		shift(wd, rd);
		repeat (8) @(posedge clk);
		mosi <= ~wd[0];
		csn_n <= 1'h1;
		repeat (8) @(posedge clk);
	endtask : xfer
endmodule : rss_host_model

/* testbench/test_radio_setup_status_registers.sv */
// Bench for the radio setup and status registers
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED %0t %s", $time, m); end end

module test_radio_setup_status_registers;
	localparam int UNIT = 8;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic sck, csn_n, mosi, miso, oe, irq_n, pa, pll, gain, rate, go, blk;
	logic rx_st = 1'h0, tx_sent = 1'h0, ack = 1'h0, aa = 1'h0, tx_full = 1'h0;
	logic tx_act = 1'h0, tx_beg = 1'h0, no_ack = 1'h0;
	logic [2:0] head = 3'h7;
	logic [2:0] ab;
	logic [39:0] addr = 40'hA1B2C3D4E5;
	logic [39:0] au;
	logic [5:0] pen;
	logic [6:0] ch;
	logic [1:0] pw;
	logic [7:0] st, rd;
	int n_fail = 0;
	int checked = 0;

	always #12.5 clk = ~clk;

	rss_regs #(.RETRY_UNIT_CYCLES(UNIT)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .spi_sck(sck), .spi_csn_n(csn_n), .spi_mosi(mosi),
		.spi_miso(miso), .spi_miso_oe(oe), .rx_payload_stored(rx_st), .rx_head_pipe(head),
		.tx_queue_full(tx_full), .tx_packet_sent(tx_sent), .ack_received(ack),
		.auto_acknowledge(aa), .tx_active(tx_act), .tx_begin(tx_beg), .tx_no_ack(no_ack),
		.stored_address(addr), .irq_n(irq_n), .pipe_receive_enable(pen),
		.address_bytes(ab), .address_used(au), .channel_number(ch),
		.air_rate_select(rate), .output_power_code(pw), .power_amp_enable(pa),
		.pll_lock_force(pll), .receiver_gain_setup(gain), .retransmit_go(go),
		.comm_blocked(blk)
	);

	rss_host_model u_host (.clk(clk), .sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso));

	task automatic rd_reg(input logic [4:0] a);
		u_host.xfer({rss_pkg::CMD_OP_READ, a}, 8'h00, st, rd);
	endtask : rd_reg

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		u_host.xfer({rss_pkg::CMD_OP_WRITE, a}, d, st, rd);
	endtask : wr_reg

	// One-cycle event pulse: bit 2 ack, bit 1 sent, bit 0 payload stored
	task automatic fire(input logic [2:0] k);
		@(posedge clk) {ack, tx_sent, rx_st} <= k;
		@(posedge clk) {ack, tx_sent, rx_st} <= 3'h0;
		repeat (3) @(posedge clk);
	endtask : fire

	task automatic miss_ack;
		@(posedge clk) no_ack <= 1'h1;
		@(posedge clk) no_ack <= 1'h0;
	endtask : miss_ack

	// Offset 0x01 is not mapped here and must read zero
	task automatic t_reset;
		logic [7:0] exp [8] = '{8'h08, 8'h00, 8'h03, 8'h03, 8'h03, 8'h02, 8'h0F, 8'h0E};
		for (int i = 0; i < 8; i++) begin
			rd_reg(5'(i));
			`CHK(rd, exp[i], "reset value")
			`CHK(st, 8'h0E, "status shifted out")
		end
		`CHK({ab, pw, ch, pll, pen, rate, gain, au}, {3'h5, 2'h3, 7'h02, 1'h0, 6'h03, 1'h1, 1'h1, addr}, "reset fields")
	endtask : t_reset

	task automatic t_fields;
		wr_reg(5'h03, 8'h01);
		`CHK(ab, 3'h3, "three bytes")
		`CHK(au, {16'h0000, addr[23:0]}, "three low bytes")
		wr_reg(5'h03, 8'h02);
		`CHK(au, {8'h00, addr[31:0]}, "four low bytes")
		wr_reg(5'h03, 8'h00);
		rd_reg(5'h03);
		`CHK(rd, 8'h02, "illegal width kept")
		wr_reg(5'h05, 8'hFF);
		rd_reg(5'h05);
		`CHK({rd, ch}, {8'h7F, 7'h7F}, "channel top bit")
		for (int p = 0; p < 4; p++) begin
			wr_reg(5'h06, {5'h01, 2'(p), 1'h0});
			`CHK({pw, pll, rate, gain}, {2'(p), 3'h2}, "power code")
		end
	endtask : t_fields

	task automatic t_status;
		head <= 3'h5;
		tx_full <= 1'h1;
		fire(3'h1);
		`CHK(irq_n, 1'h0, "irq on ready")
		wr_reg(5'h07, 8'h20);
		`CHK(st, 8'h4B, "ready pipe full")
		rd_reg(5'h07);
		`CHK(rd, 8'h4B, "zero write keeps flag")
		wr_reg(5'h07, 8'h40);
		`CHK(irq_n, 1'h1, "irq released")
		wr_reg(5'h00, 8'h48);
		fire(3'h1);
		`CHK(irq_n, 1'h1, "masked ready")
		aa <= 1'h1;
		fire(3'h2);
		rd_reg(5'h07);
		`CHK(rd, 8'h4B, "sent waits for ack")
		fire(3'h4);
		`CHK(irq_n, 1'h0, "irq on sent")
		rd_reg(5'h07);
		`CHK(rd, 8'h6B, "sent after ack")
		wr_reg(5'h07, 8'h70);
		head <= 3'h7;
		tx_full <= 1'h0;
		// Without acknowledge mode the send pulse itself sets the flag
		aa <= 1'h0;
		fire(3'h2);
		rd_reg(5'h07);
		`CHK({rd, irq_n}, {8'h2E, 1'h0}, "sent without ack")
		wr_reg(5'h07, 8'h20);
	endtask : t_status

	task automatic t_retry;
		int n;
		wr_reg(5'h04, 8'h12);
		@(posedge clk) tx_beg <= 1'h1;
		tx_act <= 1'h1;
		@(posedge clk) tx_beg <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			miss_ack();
			for (n = 1; n < 200 && go !== 1'h1; n++) @(posedge clk);
			`CHK(n >= 2 * UNIT - 1 && n <= 2 * UNIT + 2, 1'h1, "retry delay")
		end
		miss_ack();
		repeat (4) @(posedge clk);
		`CHK({blk, pa}, 2'h3, "limit reached")
		miss_ack();
		for (n = 1; n < 3 * UNIT && go !== 1'h1; n++) @(posedge clk);
		`CHK(go, 1'h0, "no resend while blocked")
		rd_reg(5'h07);
		`CHK(rd[4], 1'h1, "limit flag")
		wr_reg(5'h07, 8'h10);
		`CHK(blk, 1'h0, "unblocked")
		wr_reg(5'h04, 8'h00);
		// New packet clears the attempt count so only the zero limit can block
		@(posedge clk) tx_beg <= 1'h1;
		@(posedge clk) tx_beg <= 1'h0;
		miss_ack();
		repeat (4) @(posedge clk);
		`CHK(blk, 1'h1, "retries disabled")
		wr_reg(5'h07, 8'h10);
	endtask : t_retry

	task automatic summarize;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// Cuts a hang short and reports it as a mismatch
	initial begin
		#2ms;
		n_fail++;
		summarize();
	end

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (4) @(posedge clk);
		t_reset();
		t_fields();
		t_status();
		t_retry();
		summarize();
	end
endmodule : test_radio_setup_status_registers
